// ### core/crcr_pkg.sv
package crcr_pkg;
  // Register byte offsets on the 32-bit register bus, one aligned word each.
  localparam logic [31:0] OFF_DATA_HIGH = 32'h0000_0000;
  localparam logic [31:0] OFF_DATA_LOW = 32'h0000_0004;
  localparam logic [31:0] OFF_ACCUM_HIGH = 32'h0000_0008;
  localparam logic [31:0] OFF_ACCUM_LOW = 32'h0000_000C;
  localparam logic [31:0] OFF_SHIFTER_HIGH = 32'h0000_0010;
  localparam logic [31:0] OFF_SHIFTER_LOW = 32'h0000_0014;
  localparam logic [31:0] OFF_XOR_HIGH = 32'h0000_0018;
  localparam logic [31:0] OFF_XOR_LOW = 32'h0000_001C;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0020;
  // Values after reset.
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] ACCUM_RST = 16'h0000;
  localparam logic [15:0] SHIFTER_RST = 16'h0000;
  localparam logic [15:0] XOR_RST = 16'h0001;
  // Lowest polynomial term bit is not stored and always reads as one.
  localparam int unsigned XOR_FIXED_POS = 0;
  localparam logic XOR_FIXED_VAL = 1'b1;
  // Status field positions.
  localparam int unsigned STAT_BUSY_POS = 0;
  // Bits moved out of the shifter per load, one per clock.
  localparam logic [4:0] SHIFT_CYCLES = 5'h10;
  localparam logic [4:0] CNT_RST = 5'h00;
  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    CRCR_IDLE = 1'b0,
    CRCR_SHIFT = 1'b1
  } crcr_state_e;
endpackage

// ### core/crcr_eng_if.sv
`timescale 1ns/1ps
interface crcr_eng_if;
  logic load;
  logic [15:0] load_val;
  logic acc_wr_hi;
  logic acc_wr_lo;
  logic [7:0] wr_byte;
  logic [15:0] poly;
  logic [15:0] acc;
  logic [15:0] shift;
  logic busy;

  modport engine (
    input load, load_val, acc_wr_hi, acc_wr_lo, wr_byte, poly,
    output acc, shift, busy
  );
  modport ctrl (
    output load, load_val, acc_wr_hi, acc_wr_lo, wr_byte, poly,
    input acc, shift, busy
  );
endinterface

// ### core/crcr_engine.sv
`timescale 1ns/1ps
module crcr_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  crcr_eng_if.engine e
);
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  crcr_pkg::crcr_state_e state_r;
  crcr_pkg::crcr_state_e state_nxt;
  wire logic feedback;
  wire logic [15:0] acc_step;
  wire logic [15:0] acc_shifted;

  // The feedback bit is the leaving accumulator bit mixed with the leaving data bit.
  assign feedback = acc_r[15] ^ shift_r[15];
  assign acc_step = {acc_r[14:0], 1'b0} ^ (feedback ? e.poly : 16'h0000);
  assign acc_shifted = (state_r == crcr_pkg::CRCR_SHIFT) ? acc_step : acc_r;

  // A software byte write lands after the shift step, so software always wins that cycle.
  always_comb
  begin
    acc_nxt = acc_shifted;
    if (e.acc_wr_hi)
    begin
      acc_nxt[15:8] = e.wr_byte;
    end
    if (e.acc_wr_lo)
    begin
      acc_nxt[7:0] = e.wr_byte;
    end
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    unique case (state_r)
      crcr_pkg::CRCR_IDLE:
      begin
        cnt_nxt = cnt_r;
      end
      crcr_pkg::CRCR_SHIFT:
      begin
        shift_nxt = {shift_r[14:0], 1'b0};
        cnt_nxt = cnt_r - 5'h01;
        if (cnt_r == 5'h01)
        begin
          state_nxt = crcr_pkg::CRCR_IDLE;
        end
      end
    endcase
    // A new load restarts the shifter even in the middle of a run.
    if (e.load)
    begin
      shift_nxt = e.load_val;
      cnt_nxt = crcr_pkg::SHIFT_CYCLES;
      state_nxt = crcr_pkg::CRCR_SHIFT;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= crcr_pkg::ACCUM_RST;
      shift_r <= crcr_pkg::SHIFTER_RST;
      cnt_r <= crcr_pkg::CNT_RST;
      state_r <= crcr_pkg::CRCR_IDLE;
    end
    else if (ce)
    begin
      acc_r <= acc_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  assign e.acc = acc_r;
  assign e.shift = shift_r;
  assign e.busy = (state_r == crcr_pkg::CRCR_SHIFT);
endmodule // crcr_engine

// ### core/crcr_wcap.sv
`timescale 1ns/1ps
module crcr_wcap (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  input wire logic consume,
  output logic pend,
  output logic [31:0] addr,
  output logic [7:0] data,
  output logic lane0
);
  logic aw_full_r;
  logic w_full_r;
  logic awready_r;
  logic wready_r;
  logic [31:0] addr_r;
  logic [7:0] data_r;
  logic lane0_r;
  wire logic aw_take;
  wire logic w_take;
  wire logic aw_full_nxt;
  wire logic w_full_nxt;

  // Address and data are caught independently, so either may arrive first.
  assign aw_take = awvalid && awready_r;
  assign w_take = wvalid && wready_r;
  assign aw_full_nxt = consume ? 1'b0 : (aw_full_r || aw_take);
  assign w_full_nxt = consume ? 1'b0 : (w_full_r || w_take);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      data_r <= 8'h00;
      lane0_r <= 1'b0;
    end
    else if (ce)
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r <= !w_full_nxt;
      if (aw_take)
      begin
        addr_r <= awaddr;
      end
      if (w_take)
      begin
        data_r <= wdata[7:0];
        lane0_r <= wstrb[0];
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign pend = aw_full_r && w_full_r;
  assign addr = addr_r;
  assign data = data_r;
  assign lane0 = lane0_r;
endmodule // crcr_wcap

// ### core/crcr_top.sv
// Function
// - A 16-bit input word, split into high and low bytes, is readable and writable by software.
// - Writing the low byte of the input word loads the shifter with the whole input word.
// - The 16-bit accumulator is readable and writable in two bytes and clears to zero on every reset.
// - Writing the accumulator high byte sets its upper eight bits, and reads return its present value.
// - Writing the accumulator low byte reaches its lower eight bits through the engine's write path.
// - The shifter high byte is read-only, zero after reset, and shows the upper eight shifter bits.
// - The shifter low byte is read-only, zero after reset, shows the lower bits, and ignores writes.
// - Each set polynomial bit enables feedback on that term, and the lowest term bit always reads one.
`timescale 1ns/1ps
module crcr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a == crcr_pkg::OFF_DATA_HIGH) || (a == crcr_pkg::OFF_DATA_LOW) ||
                  (a == crcr_pkg::OFF_ACCUM_HIGH) || (a == crcr_pkg::OFF_ACCUM_LOW) ||
                  (a == crcr_pkg::OFF_SHIFTER_HIGH) || (a == crcr_pkg::OFF_SHIFTER_LOW) ||
                  (a == crcr_pkg::OFF_XOR_HIGH) || (a == crcr_pkg::OFF_XOR_LOW) ||
                  (a == crcr_pkg::OFF_STATUS);
  endfunction

  crcr_eng_if eng ();

  logic [15:0] in_word_r;
  logic [15:0] xor_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  wire logic w_pend;
  wire logic [31:0] w_addr;
  wire logic [7:0] w_byte;
  wire logic w_lane0;
  wire logic wr_go;
  wire logic wr_ok;
  wire logic wr_lane;
  wire logic wr_data_hi;
  wire logic wr_data_lo;
  wire logic wr_acc_hi;
  wire logic wr_acc_lo;
  wire logic wr_xor_hi;
  wire logic wr_xor_lo;
  wire logic [15:0] in_word_nxt;
  wire logic [15:0] xor_nxt;
  wire logic [15:0] xor_view;
  wire logic rd_take;
  wire logic rd_ok;
  wire logic [7:0] rd_byte;
  wire logic [31:0] status_word;

  crcr_wcap u_wcap (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .consume(wr_go),
    .pend(w_pend),
    .addr(w_addr),
    .data(w_byte),
    .lane0(w_lane0)
  );

  crcr_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .e(eng)
  );

  // A write completes only once the previous answer has been taken, so one answer is ever pending.
  assign wr_go = w_pend && !bvalid_r;
  assign wr_ok = wr_go && addr_mapped(w_addr);
  // Registers hold eight bits in lane zero; a write without that lane changes nothing.
  assign wr_lane = wr_ok && w_lane0;
  assign wr_data_hi = wr_lane && (w_addr == crcr_pkg::OFF_DATA_HIGH);
  assign wr_data_lo = wr_lane && (w_addr == crcr_pkg::OFF_DATA_LOW);
  assign wr_acc_hi = wr_lane && (w_addr == crcr_pkg::OFF_ACCUM_HIGH);
  assign wr_acc_lo = wr_lane && (w_addr == crcr_pkg::OFF_ACCUM_LOW);
  assign wr_xor_hi = wr_lane && (w_addr == crcr_pkg::OFF_XOR_HIGH);
  assign wr_xor_lo = wr_lane && (w_addr == crcr_pkg::OFF_XOR_LOW);

  assign in_word_nxt = {wr_data_hi ? w_byte : in_word_r[15:8], wr_data_lo ? w_byte : in_word_r[7:0]};
  assign xor_nxt = {wr_xor_hi ? w_byte : xor_r[15:8], wr_xor_lo ? w_byte[7:1] : xor_r[7:1], 1'b0};
  assign xor_view = {xor_r[15:1], crcr_pkg::XOR_FIXED_VAL};

  // The shifter takes the word as it stands after this very write.
  assign eng.load = wr_data_lo;
  assign eng.load_val = in_word_nxt;
  assign eng.acc_wr_hi = wr_acc_hi;
  assign eng.acc_wr_lo = wr_acc_lo;
  assign eng.wr_byte = w_byte;
  assign eng.poly = xor_view;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_word_r <= crcr_pkg::DATA_RST;
      xor_r <= crcr_pkg::XOR_RST;
      bvalid_r <= 1'b0;
      bresp_r <= crcr_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      in_word_r <= in_word_nxt;
      xor_r <= xor_nxt;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? crcr_pkg::RESP_OKAY : crcr_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign rd_take = s_axi_arvalid && arready_r;
  assign rd_ok = addr_mapped(s_axi_araddr);
  assign status_word = {31'h0000_0000, eng.busy};
  assign rd_byte = (s_axi_araddr == crcr_pkg::OFF_DATA_HIGH) ? in_word_r[15:8] :
                   (s_axi_araddr == crcr_pkg::OFF_DATA_LOW) ? in_word_r[7:0] :
                   (s_axi_araddr == crcr_pkg::OFF_ACCUM_HIGH) ? eng.acc[15:8] :
                   (s_axi_araddr == crcr_pkg::OFF_ACCUM_LOW) ? eng.acc[7:0] :
                   (s_axi_araddr == crcr_pkg::OFF_SHIFTER_HIGH) ? eng.shift[15:8] :
                   (s_axi_araddr == crcr_pkg::OFF_SHIFTER_LOW) ? eng.shift[7:0] :
                   (s_axi_araddr == crcr_pkg::OFF_XOR_HIGH) ? xor_view[15:8] :
                   (s_axi_araddr == crcr_pkg::OFF_XOR_LOW) ? xor_view[7:0] :
                   status_word[7:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= crcr_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= rd_ok ? crcr_pkg::RESP_OKAY : crcr_pkg::RESP_SLVERR;
        rdata_r <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
      else if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
      else if (!rvalid_r)
      begin
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule // crcr_top

// ### verif/crcr_monitor.sv
`timescale 1ns/1ps
module crcr_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  chk_write_refused: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write slot not closed");
  chk_shift_wr_okay: assert property (s_wr_take and s_axi_awaddr == crcr_pkg::OFF_SHIFTER_LOW |->
    ##2 s_axi_bvalid && s_axi_bresp == crcr_pkg::RESP_OKAY) else $error("shifter write not okay");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  chk_unmapped_read: assert property (s_rd_take and s_axi_araddr == 32'h0000_0024 |=>
    s_axi_rresp == crcr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  chk_mapped_read: assert property (s_rd_take and s_axi_araddr <= crcr_pkg::OFF_STATUS &&
    s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == crcr_pkg::RESP_OKAY) else $error("mapped read refused");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above byte");
endmodule // crcr_monitor
bind crcr_top crcr_monitor u_mon (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### verif/test_crcr_data_accum_shift_regs.sv
`timescale 1ns/1ps
module test_crcr_data_accum_shift_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0000_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [15:0] acc_m, sh_m;
  logic fb;
  int fail_count = 0;
  int total_checks = 0;
  // Each row: write flag, byte address, byte written or byte expected.
  logic [16:0] rows [24] = '{
    {1'b0, 8'h00, 8'h00}, {1'b0, 8'h04, 8'h00}, {1'b0, 8'h08, 8'h00}, {1'b0, 8'h0C, 8'h00},
    {1'b0, 8'h10, 8'h00}, {1'b0, 8'h14, 8'h00}, {1'b0, 8'h18, 8'h00}, {1'b0, 8'h1C, 8'h01},
    {1'b1, 8'h00, 8'hA5}, {1'b0, 8'h00, 8'hA5}, {1'b1, 8'h08, 8'h12}, {1'b1, 8'h0C, 8'h34},
    {1'b0, 8'h08, 8'h12}, {1'b0, 8'h0C, 8'h34}, {1'b1, 8'h1C, 8'h00}, {1'b0, 8'h1C, 8'h01},
    {1'b1, 8'h14, 8'h55}, {1'b0, 8'h14, 8'h00}, {1'b1, 8'h10, 8'h66}, {1'b0, 8'h10, 8'h00},
    {1'b1, 8'h18, 8'h80}, {1'b1, 8'h1C, 8'h04}, {1'b0, 8'h1C, 8'h05}, {1'b0, 8'h18, 8'h80}};

  crcr_top DUT (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial forever #20 clk = ~clk;

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_data({30'h0, got}, {30'h0, exp});
  endtask

  // A hung handshake ends the run here rather than stalling forever.
  task automatic tick(inout int n);
    n++;
    if (n > 100)
    begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic write_expect(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    int n;
    @(posedge clk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    n = 0;
    while (!b_t)
    begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      tick(n);
      @(posedge clk);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check_resp(resp, er);
  endtask

  task automatic read_expect(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar_t, r_t;
    int n;
    @(posedge clk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    n = 0;
    while (!r_t)
    begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      tick(n);
      @(posedge clk);
      if (ar_t)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check_data(rdat, {24'h00_0000, e});
    check_resp(resp, er);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i])
      if (rows[i][16])
        write_expect(rows[i][15:8], rows[i][7:0], crcr_pkg::RESP_OKAY);
      else
        read_expect(rows[i][15:8], rows[i][7:0], crcr_pkg::RESP_OKAY);
    // Accumulator 1234, polynomial 8005; the low data write starts sixteen shift steps.
    write_expect(8'h04, 8'h3C, crcr_pkg::RESP_OKAY);
    read_expect(8'h20, 8'h01, crcr_pkg::RESP_OKAY);
    acc_m = 16'h1234;
    sh_m = 16'hA53C;
    repeat (16)
    begin
      fb = acc_m[15] ^ sh_m[15];
      acc_m = {acc_m[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      sh_m = sh_m << 1;
    end
    repeat (20) @(posedge clk);
    read_expect(8'h08, acc_m[15:8], crcr_pkg::RESP_OKAY);
    read_expect(8'h0C, acc_m[7:0], crcr_pkg::RESP_OKAY);
    read_expect(8'h10, sh_m[15:8], crcr_pkg::RESP_OKAY);
    read_expect(8'h14, sh_m[7:0], crcr_pkg::RESP_OKAY);
    read_expect(8'h20, 8'h00, crcr_pkg::RESP_OKAY);
    read_expect(8'h04, 8'h3C, crcr_pkg::RESP_OKAY);
    read_expect(8'h24, 8'h00, crcr_pkg::RESP_SLVERR);
    write_expect(8'h02, 8'h77, crcr_pkg::RESP_SLVERR);
    read_expect(8'h00, 8'hA5, crcr_pkg::RESP_OKAY);
    // With the enable low for longer than a whole run, the shift must still be busy afterwards.
    write_expect(8'h04, 8'hC3, crcr_pkg::RESP_OKAY);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    read_expect(8'h20, 8'h01, crcr_pkg::RESP_OKAY);
    sh_m = 16'hA5C3;
    repeat (16)
    begin
      fb = acc_m[15] ^ sh_m[15];
      acc_m = {acc_m[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      sh_m = sh_m << 1;
    end
    repeat (20) @(posedge clk);
    read_expect(8'h08, acc_m[15:8], crcr_pkg::RESP_OKAY);
    read_expect(8'h0C, acc_m[7:0], crcr_pkg::RESP_OKAY);
    read_expect(8'h14, sh_m[7:0], crcr_pkg::RESP_OKAY);
    // A reset while the engine is idle must clear what software left behind.
    write_expect(8'h08, 8'hFF, crcr_pkg::RESP_OKAY);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    read_expect(8'h08, 8'h00, crcr_pkg::RESP_OKAY);
    read_expect(8'h10, 8'h00, crcr_pkg::RESP_OKAY);
    read_expect(8'h1C, 8'h01, crcr_pkg::RESP_OKAY);
    test_done();
  end
endmodule // test_crcr_data_accum_shift_regs
